// [dv/umhf_link_asserts.sv]
// Checker for the link between the modem and headend ends.
// Assumes it watches the first link, driven by the design modem end.
`timescale 1ns/100ps
module umhf_link_asserts
    import umhf_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic       valid,
    input  wire logic       ready,
    input  wire logic [7:0] data,
    input  wire logic       sop,
    input  wire logic       eop
);
    // ====================================================
    // Burst starts
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic tk;
    logic s_req;
    logic s_frag;
    logic s_cat;
    assign tk     = valid && ready;
    assign s_req  = tk && sop && data[5:1] == UMHF_PARAM_REQ;
    assign s_frag = tk && sop && data[5:1] == UMHF_PARAM_FRAG;
    assign s_cat  = tk && sop && data[5:1] == UMHF_PARAM_CONCAT;
    AST_KIND_MAC: assert property (tk && sop |-> data[7:6] == 2'h3)
        else $error("burst does not start with a MAC header");
    AST_REQ_NO_EXT: assert property (s_req |-> !data[0])
        else $error("request header has extension flag");
    AST_REQ_SIX: assert property (s_req |-> ##5 (tk && eop))
        else $error("request header is not six bytes");
    AST_REQ_ALONE: assert property (s_req |-> ##6 !(valid && !sop))
        else $error("data follows a request header");
    AST_FRAG_EXT: assert property (s_frag |-> data[0])
        else $error("fragment header lacks extension flag");
    AST_FRAG_EXT_HEADER_SIZE: assert property (s_frag |=> tk && data == 8'h06)
        else $error("fragment extension size is not six");
    AST_CAT_NO_EXT: assert property (s_cat |-> !data[0])
        else $error("concatenation header has extension flag");
    // The modem spends one idle cycle taking the embedded command.
    AST_CAT_NEXT: assert property (
        s_cat |-> ##6 !(valid && sop) ##1 (tk && !sop && data[7:6] == 2'h3))
        else $error("first embedded header does not follow");
    AST_CAT_ONCE: assert property (s_cat |=> (!(valid && sop))[*8])
        else $error("second header start inside a concatenation");
endmodule

// [dv/upstream_mac_special_header_framer_bench.sv]
// Bench joining the modem and headend ends, with a model in queues.
// Assumes always-ready headend and the byte layout of the hand-over.
`timescale 1ns/100ps
module upstream_mac_special_header_framer_bench;
    import umhf_pkg::*;
    logic clk = 0, rst = 1, cmd_valid = 0, pay_valid = 0, pay_last = 0;
    umhf_cmd_t cmd_kind = UMHF_CMD_REQ;
    logic [7:0] cmd_param = 0, pay_data = 0, rnd = 8'h4a, hfc, hpar, pd;
    logic [15:0] cmd_len = 0, hlen;
    logic [47:0] cmd_ext = 0;
    logic cmd_ready, pay_ready, hv, hbad, pv, fdone, fok, hv2, hbad2, busy;
    logic [31:0] lq[$], hq[$], pq[$];
    int failures = 0, total_checks = 0, done_n = 0, bad_n = 0;
    umhf_link_if lnk();
    umhf_link_if lnk2();
    initial {lnk2.valid, lnk2.sop, lnk2.eop, lnk2.data} = 11'h055;
    always #5 clk = ~clk;
    umhf_modem_tx i_umhf_modem_tx (.CLK_I(clk), .RST_I(rst),
        .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready),
        .CMD_KIND_I(cmd_kind), .CMD_PARAM_I(cmd_param), .CMD_LEN_I(cmd_len),
        .CMD_EXT_I(cmd_ext), .PAY_VALID_I(pay_valid),
        .PAY_READY_O(pay_ready), .PAY_DATA_I(pay_data),
        .PAY_LAST_I(pay_last), .BUSY_O(busy), .link(lnk));
    umhf_headend_rx i_umhf_headend_rx (.CLK_I(clk), .RST_I(rst), .link(lnk),
        .HDR_VALID_O(hv), .HDR_FC_O(hfc), .HDR_PARAM_O(hpar),
        .HDR_LEN_O(hlen), .HDR_BAD_O(hbad), .PAY_VALID_O(pv),
        .PAY_DATA_O(pd), .FRAG_DONE_O(fdone), .FRAG_CRC_OK_O(fok));
    // Second receiver faces a bench driver that corrupts the check field.
    umhf_headend_rx i_umhf_headend_rx_err (.CLK_I(clk), .RST_I(rst),
        .link(lnk2), .HDR_VALID_O(hv2), .HDR_FC_O(), .HDR_PARAM_O(),
        .HDR_LEN_O(), .HDR_BAD_O(hbad2), .PAY_VALID_O(), .PAY_DATA_O(),
        .FRAG_DONE_O(), .FRAG_CRC_OK_O());
    umhf_link_asserts i_umhf_link_asserts (.CLK_I(clk), .RST_I(rst),
        .valid(lnk.valid), .ready(lnk.ready), .data(lnk.data),
        .sop(lnk.sop), .eop(lnk.eop));

    // ====================================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] rstep(input logic [31:0] c,
                                          input logic [7:0] d,
                                          input logic [31:0] p);
        c = c ^ {24'h0, d};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ p) : (c >> 1);
        return c;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic take(input logic [31:0] got, ref logic [31:0] q[$]);
        check(got, q.size() ? q.pop_front() : 32'hffffffff);
    endtask
    task automatic wait_rdy(input int sel);
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge clk);
            if ((sel == 2 ? !busy : sel ? pay_ready : cmd_ready) === 1'b1)
                break;
        end
        if (n == 300) check(32'h0, 32'h1);
        @(posedge clk);
    endtask
    task automatic push_hdr(input logic [7:0] fc, input logic [7:0] par,
                            input logic [15:0] len, input int ne,
                            input logic [47:0] x, input logic s, input logic e);
        logic [7:0] b[$];
        logic [31:0] h;
        b = '{fc, par, len[15:8], len[7:0]};
        for (int i = 0; i < ne; i++) b.push_back(x[47-8*i -: 8]);
        h = 32'hffff;
        foreach (b[i]) h = rstep(h, b[i], 32'h8408);
        h = ~h;
        b.push_back(h[7:0]);
        b.push_back(h[15:8]);
        foreach (b[i]) lq.push_back({22'h0, s && i == 0, e && i == 5, b[i]});
        hq.push_back({fc, par, len});
    endtask
    task automatic send_cmd(input umhf_cmd_t k, input logic [7:0] p,
                            input logic [15:0] l, input logic [47:0] x);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_param <= p;
        cmd_len <= l;
        cmd_ext <= x;
        wait_rdy(0);
    endtask
    task automatic req(input logic [7:0] ask, input logic [15:0] service_flow_id,
                       input logic alone);
        push_hdr({2'h3, 5'h02, 1'b0}, ask, service_flow_id, 0, 0, alone, alone);
        send_cmd(UMHF_CMD_REQ, ask, service_flow_id, {6{rnd}});
    endtask
    task automatic frag(input int n);
        logic [47:0] x;
        logic [31:0] c;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            x[8*i +: 8] = rnd;
        end
        push_hdr({2'h3, 5'h03, 1'b1}, 8'h06, 16'(n + 10), 6, x, 1, 0);
        send_cmd(UMHF_CMD_FRAG, rnd, 16'(n), x);
        cmd_valid <= 1'b0;
        c = 32'hffffffff;
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            c = rstep(c, rnd, 32'hedb88320);
            lq.push_back({24'h0, rnd});
            pq.push_back({24'h0, rnd});
            pay_valid <= 1'b1;
            pay_data <= rnd;
            pay_last <= i == n - 1;
            wait_rdy(1);
        end
        pay_valid <= 1'b0;
        c = ~c;
        for (int i = 0; i < 4; i++) begin
            lq.push_back({22'h0, 1'b0, i == 3, c[8*i +: 8]});
            pq.push_back({24'h0, c[8*i +: 8]});
        end
    endtask
    task automatic concat(input logic [7:0] tally, input int nreq);
        push_hdr({2'h3, 5'h1c, 1'b0}, tally, 16'(6 * nreq), 0, 0, 1, 0);
        send_cmd(UMHF_CMD_CONCAT, tally, 16'(6 * nreq), 0);
        for (int i = 0; i < nreq; i++) begin
            rnd = lfsr(rnd);
            if (i == 1) send_cmd(UMHF_CMD_CONCAT, 8'h00, 16'h0000, 0);
            req(rnd, 16'h0123, 1'b0);
        end
        cmd_valid <= 1'b0;
        lq.push_back({22'h0, 2'b01, 8'h00});
        // A new burst may only start once the open one has closed.
        wait_rdy(2);
    endtask
    task automatic bad_hdr;
        logic [7:0] b[6];
        logic [31:0] h;
        b = '{8'hc4, 8'h10, 8'h00, 8'h05, 8'h00, 8'h00};
        h = 32'hffff;
        for (int i = 0; i < 4; i++) h = rstep(h, b[i], 32'h8408);
        h = ~h ^ 32'h1;
        {b[5], b[4]} = h[15:0];
        for (int i = 0; i < 6; i++) begin
            {lnk2.valid, lnk2.sop, lnk2.eop, lnk2.data} <= {1'b1, i == 0, i == 5, b[i]};
            @(posedge clk);
        end
        {lnk2.valid, lnk2.sop, lnk2.eop, lnk2.data} <= {3'b000, ~b[5]};
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ====================================================
    // Monitors and sequence
    always @(negedge clk) begin
        if (lnk.valid === 1'b1 && lnk.ready === 1'b1) begin
            check({31'h0, busy}, {31'h0, lq.size() > 0 && !lq[0][8]});
            take({22'h0, lnk.sop, lnk.eop, lnk.data}, lq);
        end
        if (hv === 1'b1) take({hfc, hpar, hlen}, hq);
        if (pv === 1'b1) take({24'h0, pd}, pq);
        if (hbad === 1'b1) check(32'h1, 32'h0);
        if (hv2 === 1'b1) check(32'h1, 32'h0);
        if (hbad2 === 1'b1) bad_n++;
        if (fdone === 1'b1) begin
            done_n++;
            check({31'h0, fok}, 32'h1);
        end
    end
    initial begin
        #500000;
        failures++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            req(i ? rnd : 8'hff, i ? {3'h0, rnd, rnd[4:0]} : 16'h1fff, 1);
        end
        cmd_valid <= 1'b0;
        @(posedge clk);
        frag(1);
        frag(5);
        concat(8'h01, 1);
        @(posedge clk);
        concat(8'h00, 2);
        bad_hdr();
        repeat (60) @(posedge clk);
        check(32'(lq.size() + hq.size() + pq.size()), 32'h0);
        check(32'(done_n), 32'h2);
        check(32'(bad_n), 32'h1);
        conclude();
    end
endmodule

// [hw/umhf_headend_rx.sv]
// Headend end: parses request, fragment and concatenation headers.
// Assumes the modem end keeps the header layouts it is bound to.
`timescale 1ns/100ps
module umhf_headend_rx
    import umhf_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    umhf_link_if.headend     link,
    output logic             HDR_VALID_O,
    output logic [7:0]       HDR_FC_O,
    output logic [7:0]       HDR_PARAM_O,
    output logic [15:0]      HDR_LEN_O,
    output logic             HDR_BAD_O,
    output logic             PAY_VALID_O,
    output logic [7:0]       PAY_DATA_O,
    output logic             FRAG_DONE_O,
    output logic             FRAG_CRC_OK_O
);

    // =========================================================
    // State
    typedef enum logic [2:0] {
        R_HDR  = 3'b001,
        R_PAY  = 3'b010,
        R_SKIP = 3'b100
    } umhf_rx_state_t;

    typedef struct packed {
        umhf_rx_state_t st;
        logic [0:3][7:0] hb;
        logic [3:0]     idx;
        logic [3:0]     hlen;
        logic [15:0]    header_check;
        logic [31:0]    crc;
        logic [15:0]    left;
        logic           frag;
        logic           hv;
        logic           bad;
        logic           pv;
        logic [7:0]     pd;
        logic           fd;
        logic           fok;
    } umhf_rx_t;

    umhf_rx_t r;
    umhf_rx_t next_r;
    logic     acc;

    assign link.ready = 1'b1;
    assign acc = link.valid;

    // =========================================================
    // Next state
    always_comb begin
        next_r = r;
        next_r.hv = 1'b0;
        next_r.bad = 1'b0;
        next_r.pv = 1'b0;
        next_r.fd = 1'b0;
        if (acc && link.sop) begin
            next_r.st = R_HDR;
            next_r.idx = 4'h0;
        end
        case (next_r.st)
            R_HDR: begin
                if (acc) begin
                    if (next_r.idx == 4'h0) begin
                        next_r.header_check = UMHF_HCS_INIT;
                        next_r.hlen = link.data[0] ?
                            4'(UMHF_HDR_BYTES + UMHF_FRAG_EH_BYTES) :
                            4'(UMHF_HDR_BYTES);
                    end
                    if (next_r.idx < 4'(UMHF_HDR_BYTES - 2)) begin
                        next_r.hb[next_r.idx[1:0]] = link.data;
                    end
                    next_r.header_check = umhf_hcs(next_r.idx == 4'h0 ?
                                          UMHF_HCS_INIT : r.header_check, link.data);
                    next_r.idx = next_r.idx + 4'h1;
                    if (next_r.idx == next_r.hlen) begin
                        // Residue of a good header check is fixed.
                        next_r.bad = (next_r.header_check != UMHF_HCS_RESIDUE);
                        next_r.hv = !next_r.bad;
                        next_r.idx = 4'h0;
                        next_r.frag = (next_r.hb[0] ==
                                       umhf_fc(UMHF_PARAM_FRAG, 1'b1));
                        next_r.left = {next_r.hb[2], next_r.hb[3]};
                        next_r.crc = UMHF_CRC_INIT;
                        if (next_r.bad) begin
                            next_r.st = R_SKIP;
                        end else if (next_r.frag) begin
                            // Only payload plus CRC remains after header.
                            next_r.left = next_r.left -
                                16'(UMHF_FRAG_EH_BYTES);
                            next_r.st = R_PAY;
                        end else if (next_r.hb[0] ==
                                     umhf_fc(UMHF_PARAM_CONCAT, 1'b0) ||
                                     next_r.hb[0] ==
                                     umhf_fc(UMHF_PARAM_REQ, 1'b0)) begin
                            // Next header follows at once; request
                            // length field is a flow id.
                            next_r.st = R_HDR;
                        end else begin
                            next_r.st = (next_r.left == 16'h0000) ?
                                        R_HDR : R_PAY;
                        end
                    end
                end
            end
            R_PAY, R_SKIP: begin
                if (acc) begin
                    next_r.pv = (r.st == R_PAY);
                    next_r.pd = link.data;
                    next_r.crc = umhf_crc32(r.crc, link.data);
                    next_r.left = r.left - 16'h0001;
                    if (r.left == 16'h0001) begin
                        next_r.st = R_HDR;
                        next_r.fd = r.frag && (r.st == R_PAY);
                        next_r.fok = (next_r.crc == UMHF_CRC_RESIDUE);
                        next_r.frag = 1'b0;
                    end
                end
            end
            default: next_r.st = R_HDR;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= '0;
            r.st <= R_HDR;
        end else begin
            r <= next_r;
        end
    end

    assign HDR_VALID_O   = r.hv;
    assign HDR_FC_O      = r.hb[0];
    assign HDR_PARAM_O   = r.hb[1];
    assign HDR_LEN_O     = {r.hb[2], r.hb[3]};
    assign HDR_BAD_O     = r.bad;
    assign PAY_VALID_O   = r.pv;
    assign PAY_DATA_O    = r.pd;
    assign FRAG_DONE_O   = r.fd;
    assign FRAG_CRC_OK_O = r.fok;

endmodule

// [hw/umhf_link_if.sv]
// Byte stream link between modem transmitter and headend receiver.
// Assumes one shared clock; sop marks first byte of a burst.
`timescale 1ns/100ps
interface umhf_link_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    logic       sop;
    logic       eop;

    modport modem (output valid, output data, output sop, output eop,
                   input ready);
    modport headend (input valid, input data, input sop, input eop,
                     output ready);
endinterface

// [hw/umhf_modem_tx.sv]
// Modem end: builds request, fragment and concatenation headers.
// Assumes the user supplies payload bytes with valid/ready handshaking.
`timescale 1ns/100ps
module umhf_modem_tx
    import umhf_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CMD_VALID_I,
    output logic             CMD_READY_O,
    input  wire umhf_cmd_t   CMD_KIND_I,
    input  wire logic [7:0]  CMD_PARAM_I,
    input  wire logic [15:0] CMD_LEN_I,
    input  wire logic [47:0] CMD_EXT_I,
    input  wire logic        PAY_VALID_I,
    output logic             PAY_READY_O,
    input  wire logic [7:0]  PAY_DATA_I,
    input  wire logic        PAY_LAST_I,
    output logic             BUSY_O,
    umhf_link_if.modem       link
);

    // =========================================================
    // State
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_HDR  = 5'b00010,
        S_PAY  = 5'b00100,
        S_CRC  = 5'b01000,
        S_CAT  = 5'b10000
    } umhf_tx_state_t;

    typedef struct packed {
        umhf_tx_state_t st;
        umhf_cmd_t      kind;
        logic [0:11][7:0] hdr;
        logic [3:0]     idx;
        logic [3:0]     hlen;
        logic [15:0]    header_check;
        logic [31:0]    crc;
        logic [15:0]    left;
        logic           cat_open;
        logic           vld;
        logic [7:0]     dat;
        logic           sop;
        logic           eop;
    } umhf_tx_t;

    umhf_tx_t r;
    umhf_tx_t next_r;
    logic     take;

    assign take = link.ready || !r.vld;

    // =========================================================
    // Next state
    always_comb begin
        next_r = r;
        CMD_READY_O = 1'b0;
        PAY_READY_O = 1'b0;
        if (take) begin
            next_r.vld = 1'b0;
            next_r.sop = 1'b0;
            next_r.eop = 1'b0;
        end
        case (r.st)
            S_IDLE, S_CAT: begin
                CMD_READY_O = take;
                if (CMD_VALID_I && take) begin
                    next_r.kind = CMD_KIND_I;
                    next_r.idx = 4'h0;
                    next_r.header_check = UMHF_HCS_INIT;
                    next_r.crc = UMHF_CRC_INIT;
                    next_r.left = CMD_LEN_I;
                    next_r.hdr[1] = CMD_PARAM_I;
                    next_r.hdr[2] = CMD_LEN_I[15:8];
                    next_r.hdr[3] = CMD_LEN_I[7:0];
                    for (int i = 0; i < UMHF_FRAG_EH_BYTES; i++) begin
                        next_r.hdr[UMHF_HDR_BYTES - 2 + i] =
                            CMD_EXT_I[47 - 8 * i -: 8];
                    end
                    next_r.st = S_HDR;
                    case (CMD_KIND_I)
                        UMHF_CMD_REQ: begin
                            next_r.hdr[0] = umhf_fc(UMHF_PARAM_REQ, 1'b0);
                            next_r.hlen = 4'(UMHF_HDR_BYTES - 2);
                        end
                        UMHF_CMD_FRAG: begin
                            next_r.hdr[0] = umhf_fc(UMHF_PARAM_FRAG, 1'b1);
                            next_r.hdr[1] = UMHF_FRAG_EXT_HEADER_SIZE;
                            {next_r.hdr[2], next_r.hdr[3]} =
                                16'(CMD_LEN_I + UMHF_FRAG_EXTRA);
                            next_r.hlen = 4'(UMHF_HDR_BYTES - 2 +
                                             UMHF_FRAG_EH_BYTES);
                        end
                        default: begin
                            // A nested concatenation command is taken and dropped; the state stays S_CAT.
                            if (r.st == S_CAT) begin
                                next_r.st = S_CAT;
                            end
                            next_r.hdr[0] = umhf_fc(UMHF_PARAM_CONCAT, 1'b0);
                            next_r.hlen = 4'(UMHF_HDR_BYTES - 2);
                            next_r.cat_open = 1'b1;
                        end
                    endcase
                end
            end
            S_HDR: begin
                if (take) begin
                    next_r.vld = 1'b1;
                    next_r.sop = (r.idx == 4'h0) && !r.cat_open;
                    if (r.idx < r.hlen) begin
                        next_r.dat = r.hdr[r.idx];
                        next_r.header_check = umhf_hcs(r.header_check, r.hdr[r.idx]);
                    end else if (r.idx == r.hlen) begin
                        next_r.dat = ~r.header_check[7:0];
                    end else begin
                        next_r.dat = ~r.header_check[15:8];
                    end
                    if (r.kind == UMHF_CMD_CONCAT && r.idx == 4'h0) begin
                        next_r.sop = 1'b1;
                    end
                    next_r.idx = r.idx + 4'h1;
                    if (r.idx == r.hlen + 4'h1) begin
                        if (r.kind == UMHF_CMD_FRAG) begin
                            next_r.st = S_PAY;
                        end else if (r.kind == UMHF_CMD_CONCAT) begin
                            next_r.st = S_CAT;
                        end else begin
                            // A request ends at its header.
                            next_r.eop = !r.cat_open;
                            next_r.st = r.cat_open ? S_CAT : S_IDLE;
                        end
                    end
                end
            end
            S_PAY: begin
                PAY_READY_O = take;
                if (PAY_VALID_I && take) begin
                    next_r.vld = 1'b1;
                    next_r.dat = PAY_DATA_I;
                    next_r.crc = umhf_crc32(r.crc, PAY_DATA_I);
                    if (PAY_LAST_I) begin
                        next_r.idx = 4'h0;
                        next_r.st = S_CRC;
                    end
                end
            end
            S_CRC: begin
                if (take) begin
                    next_r.vld = 1'b1;
                    next_r.dat = ~r.crc[8 * r.idx[1:0] +: 8];
                    next_r.idx = r.idx + 4'h1;
                    if (r.idx == 4'(UMHF_CRC_BYTES - 1)) begin
                        next_r.eop = !r.cat_open;
                        next_r.st = r.cat_open ? S_CAT : S_IDLE;
                    end
                end
            end
            default: next_r.st = S_IDLE;
        endcase
        // Closing an open burst: an idle concatenation ends on command loss.
        if (r.st == S_CAT && !CMD_VALID_I && take && r.cat_open) begin
            next_r.cat_open = 1'b0;
            next_r.vld = 1'b1;
            next_r.eop = 1'b1;
            next_r.dat = 8'h00;
            next_r.st = S_IDLE;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= '0;
            r.st <= S_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign link.valid = r.vld;
    assign link.data  = r.dat;
    assign link.sop   = r.sop;
    assign link.eop   = r.eop;
    assign BUSY_O     = (r.st != S_IDLE);

endmodule

// [hw/umhf_pkg.sv]
// Constants and types shared by both ends of the upstream header framer.
// Assumes a byte-wide stream link between modem and headend ends.
package umhf_pkg;

    // =========================================================
    // Header field layout
    localparam logic [1:0] UMHF_KIND_MAC      = 2'h3;
    localparam logic [4:0] UMHF_PARAM_REQ     = 5'h02;
    localparam logic [4:0] UMHF_PARAM_FRAG    = 5'h03;
    localparam logic [4:0] UMHF_PARAM_CONCAT  = 5'h1c;
    localparam int         UMHF_HDR_BYTES     = 6;
    localparam int         UMHF_FRAG_EH_BYTES = 6;
    localparam int         UMHF_CRC_BYTES     = 4;
    localparam logic [7:0] UMHF_FRAG_EXT_HEADER_SIZE     = 8'h06;
    localparam logic [15:0] UMHF_FRAG_EXTRA   = 16'h000a;
    localparam logic [31:0] UMHF_CRC_INIT     = 32'hffffffff;
    localparam logic [31:0] UMHF_CRC_POLY     = 32'hedb88320;
    localparam logic [31:0] UMHF_CRC_RESIDUE  = 32'hdebb20e3;
    localparam logic [15:0] UMHF_HCS_INIT     = 16'hffff;
    localparam logic [15:0] UMHF_HCS_POLY     = 16'h8408;
    localparam logic [15:0] UMHF_HCS_RESIDUE  = 16'hf0b8;

    // =========================================================
    // Command kinds
    typedef enum logic [1:0] {
        UMHF_CMD_REQ    = 2'h0,
        UMHF_CMD_FRAG   = 2'h1,
        UMHF_CMD_CONCAT = 2'h2
    } umhf_cmd_t;

    // =========================================================
    // Checksums, bytewise, reflected.
    function automatic logic [31:0] umhf_crc32(input logic [31:0] c,
                                               input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ UMHF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [15:0] umhf_hcs(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ UMHF_HCS_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] umhf_fc(input logic [4:0] p,
                                           input logic eh);
        return {UMHF_KIND_MAC, p, eh};
    endfunction

endpackage
